// [core/eslx_pkg.sv]
package eslx_pkg;

  localparam int DATA_W    = 32;
  localparam int PFX_W     = 11;
  localparam int SHORT_IMMEDIATE_W    = 5;
  localparam int SHAMT_W   = 5;
  localparam int BASE_SEL_W = 2;
  localparam int BASE_CNT  = 4;
  localparam int BASE_IDX_OFS = 16;
  localparam int WORD_SHIFT = 2;
  localparam logic [31:0] ALIGN_MASK = 32'hffff_fffc;

  typedef enum logic [3:0] {
    ESLX_OP_NONE,
    ESLX_OP_HW_EXT_DYN,
    ESLX_OP_HW_EXT_STAT,
    ESLX_OP_BYTE_EXT_DYN,
    ESLX_OP_BYTE_EXT_STAT,
    ESLX_OP_BYTE_REPL,
    ESLX_OP_HW_REPL,
    ESLX_OP_JUMP,
    ESLX_OP_LOAD_REG,
    ESLX_OP_LOAD_PTR,
    ESLX_OP_SHL_REG,
    ESLX_OP_SHL_IMM,
    ESLX_OP_SHR_REG,
    ESLX_OP_SHR_IMM,
    ESLX_OP_COPY,
    ESLX_OP_PREFIX
  } eslx_op_type;

  typedef struct packed {
    eslx_op_type  op;
    logic [31:0]  reg_a;
    logic [31:0]  reg_b;
    logic [4:0]   short_imm;
    logic [1:0]   base_sel;
    logic [10:0]  prefix_imm;
    logic [4:0]   dest_idx;
  } eslx_req_type;

  typedef struct packed {
    logic         wr_en;
    logic [4:0]   wr_idx;
    logic [31:0]  wr_data;
  } eslx_wb_type;

  typedef struct packed {
    logic         valid;
    logic [31:0]  addr;
  } eslx_mem_req_type;

  localparam logic [4:0] ACC_REG_IDX = 5'h00;

endpackage : eslx_pkg

// [core/eslx_extract.sv]
`timescale 1ns/1ps
module eslx_extract (
  // Operands
  input  wire eslx_pkg::eslx_op_type op,
  input  wire logic [31:0]          reg_a,
  input  wire logic [31:0]          reg_b,
  input  wire logic [4:0]           short_imm,
  // Result
  output logic [31:0]               result
);
  import eslx_pkg::*;

  // Static selects live in the low immediate bits of the instruction word.
  wire logic        hw_sel_dyn   = reg_b[1];
  wire logic        hw_sel_stat  = short_imm[1];
  wire logic [1:0]  byte_sel_dyn = reg_b[1:0];
  wire logic [1:0]  byte_sel_stat = short_imm[1:0];
  wire logic        hw_sel;
  wire logic [1:0]  byte_sel;
  wire logic [15:0] hw_pick;
  wire logic [7:0]  byte_pick;

  assign hw_sel   = (op == ESLX_OP_HW_EXT_DYN) ? hw_sel_dyn : hw_sel_stat;
  assign byte_sel = (op == ESLX_OP_BYTE_EXT_DYN) ? byte_sel_dyn
                                                  : byte_sel_stat;
  assign hw_pick   = hw_sel ? reg_a[31:16] : reg_a[15:0];
  assign byte_pick = reg_a[8*byte_sel +: 8];

  always_comb begin
    case (op)
      ESLX_OP_HW_EXT_DYN,
      ESLX_OP_HW_EXT_STAT: result = {16'h0000, hw_pick};
      ESLX_OP_BYTE_EXT_DYN,
      ESLX_OP_BYTE_EXT_STAT: result = {24'h00_0000, byte_pick};
      ESLX_OP_BYTE_REPL: result = {4{reg_a[7:0]}};
      ESLX_OP_HW_REPL: result = {2{reg_a[15:0]}};
      default: result = 32'h0000_0000;
    endcase
  end

endmodule : eslx_extract

// [core/eslx_shift.sv]
`timescale 1ns/1ps
module eslx_shift (
  // Operands
  input  wire eslx_pkg::eslx_op_type op,
  input  wire logic [31:0]          reg_a,
  input  wire logic [31:0]          reg_b,
  input  wire logic [4:0]           short_imm,
  // Result
  output logic [31:0]               result
);
  import eslx_pkg::*;

  wire logic [SHAMT_W-1:0] amount;
  wire logic               use_reg;
  wire logic               go_left;

  assign use_reg = (op == ESLX_OP_SHL_REG) || (op == ESLX_OP_SHR_REG);
  assign go_left = (op == ESLX_OP_SHL_REG) || (op == ESLX_OP_SHL_IMM);
  assign amount  = use_reg ? reg_b[SHAMT_W-1:0] : short_imm;

  // Both directions are logical, so vacated bits always come in as zero.
  assign result = go_left ? (reg_a << amount)
                          : (reg_a >> amount);

endmodule : eslx_shift

// [core/eslx_exec.sv]
`timescale 1ns/1ps
// Functional notes
// - Dynamic halfword extract by operand B bit one
// - Static halfword extract by one-bit immediate
// - Dynamic byte extract by operand B low bits
// - Static byte extract by two-bit immediate
// - Byte replicate into register zero only
// - Register load uses word-aligned operand B address
// - Pointer load ignores base pointer low bits
// - Unprefixed pointer offset is immediate times four
// - Two-bit field picks one of four bases
// - Prefixed offset sign-extended, scaled, added to base
// - Immediate left shift fills zeros
// - Immediate right shift fills zeros
// - Copy writes operand B into target A
// - Prefix loads constant; others clear it
module eslx_exec (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    nrst,
  // Issued instruction
  input  wire logic                    issue_valid,
  input  wire eslx_pkg::eslx_req_type  issue_req,
  output logic                         issue_ready,
  // Local base registers from the register file
  input  wire logic [4*32-1:0]         local_base_regs,
  // Data memory
  output eslx_pkg::eslx_mem_req_type   mem_req,
  input  wire logic                    mem_rvalid,
  input  wire logic [31:0]             mem_rdata,
  // Register write-back
  output eslx_pkg::eslx_wb_type        wb,
  // Program counter redirect
  output logic                         pc_load,
  output logic [31:0]                  pc_target,
  // Prefix constant
  output logic [10:0]                  prefix_constant_register
);
  import eslx_pkg::*;

  typedef enum logic [1:0] {
    ESLX_ST_IDLE,
    ESLX_ST_WAIT_MEM
  } eslx_state_type;

  eslx_state_type state_reg;
  eslx_state_type state_next;
  logic [10:0]    pfx_reg;
  logic [10:0]    pfx_next;
  logic [4:0]     load_dest_reg;
  eslx_mem_req_type mem_reg;
  eslx_mem_req_type mem_next;
  eslx_wb_type    wb_reg;
  eslx_wb_type    wb_next;
  logic           pc_load_reg;
  logic [31:0]    pc_target_reg;
  logic [31:0]    ext_result;
  logic [31:0]    shift_result;

  wire logic        take;
  wire eslx_op_type op;
  wire logic        is_load;
  wire logic        is_extract;
  wire logic        is_shift;
  wire logic        is_repl;
  wire logic        has_prefix;
  wire logic [31:0] base_raw;
  wire logic [31:0] base_aligned;
  wire logic [15:0] long_ofs;
  wire logic [31:0] ptr_ofs;
  wire logic [31:0] ptr_addr;
  wire logic [31:0] reg_addr;
  wire logic [31:0] load_addr;
  wire logic [4:0]  dest_idx;

  assign issue_ready = (state_reg == ESLX_ST_IDLE);
  assign take        = issue_valid && issue_ready;
  assign op          = issue_req.op;
  assign is_load     = (op == ESLX_OP_LOAD_REG) || (op == ESLX_OP_LOAD_PTR);
  assign is_extract  = (op == ESLX_OP_HW_EXT_DYN) ||
                       (op == ESLX_OP_HW_EXT_STAT) ||
                       (op == ESLX_OP_BYTE_EXT_DYN) ||
                       (op == ESLX_OP_BYTE_EXT_STAT) || is_repl;
  assign is_repl     = (op == ESLX_OP_BYTE_REPL) || (op == ESLX_OP_HW_REPL);
  assign is_shift    = (op == ESLX_OP_SHL_REG) || (op == ESLX_OP_SHL_IMM) ||
                       (op == ESLX_OP_SHR_REG) || (op == ESLX_OP_SHR_IMM);
  assign has_prefix  = (pfx_reg != 11'h000);

  // Base selection; field value is the register index less the offset.
  assign base_raw     = local_base_regs[32*issue_req.base_sel +: 32];
  assign base_aligned = base_raw & ALIGN_MASK;
  // A zero prefix counts as no prefix; only a nonzero one takes the sign-extended path.
  assign long_ofs = {pfx_reg, issue_req.short_imm};
  assign ptr_ofs  = has_prefix
                  ? {{14{long_ofs[15]}}, long_ofs, 2'b00}
                  : {25'h000_0000, issue_req.short_imm, 2'b00};
  assign ptr_addr = base_aligned + ptr_ofs;
  assign reg_addr = issue_req.reg_b & ALIGN_MASK;
  assign load_addr = (op == ESLX_OP_LOAD_PTR) ? ptr_addr : reg_addr;
  // Replicate ops always land in register zero.
  assign dest_idx = is_repl ? ACC_REG_IDX : issue_req.dest_idx;

  eslx_extract u_extract (
    .op        (op),
    .reg_a     (issue_req.reg_a),
    .reg_b     (issue_req.reg_b),
    .short_imm (issue_req.short_imm),
    .result    (ext_result)
  );

  eslx_shift u_shift (
    .op        (op),
    .reg_a     (issue_req.reg_a),
    .reg_b     (issue_req.reg_b),
    .short_imm (issue_req.short_imm),
    .result    (shift_result)
  );

  always_comb begin
    state_next = state_reg;
    pfx_next   = pfx_reg;
    mem_next   = '0;
    wb_next    = '0;
    case (state_reg)
      ESLX_ST_IDLE: begin
        if (take) begin
          // Every instruction except a prefix clears the constant.
          pfx_next = (op == ESLX_OP_PREFIX) ? issue_req.prefix_imm
                                            : 11'h000;
          if (is_load) begin
            mem_next.valid = 1'b1;
            mem_next.addr  = load_addr;
            state_next     = ESLX_ST_WAIT_MEM;
          end else if (is_extract) begin
            wb_next.wr_en   = 1'b1;
            wb_next.wr_idx  = dest_idx;
            wb_next.wr_data = ext_result;
          end else if (is_shift) begin
            wb_next.wr_en   = 1'b1;
            wb_next.wr_idx  = dest_idx;
            wb_next.wr_data = shift_result;
          end else if (op == ESLX_OP_COPY) begin
            wb_next.wr_en   = 1'b1;
            wb_next.wr_idx  = dest_idx;
            wb_next.wr_data = issue_req.reg_b;
          end
        end
      end
      ESLX_ST_WAIT_MEM: begin
        if (mem_rvalid) begin
          wb_next.wr_en   = 1'b1;
          wb_next.wr_idx  = load_dest_reg;
          wb_next.wr_data = mem_rdata;
          state_next      = ESLX_ST_IDLE;
        end
      end
      default: state_next = ESLX_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg     <= ESLX_ST_IDLE;
      pfx_reg       <= 11'h000;
      mem_reg       <= '0;
      wb_reg        <= '0;
      load_dest_reg <= 5'h00;
    end else begin
      state_reg <= state_next;
      pfx_reg   <= pfx_next;
      mem_reg   <= mem_next;
      wb_reg    <= wb_next;
      if (take && is_load) begin
        load_dest_reg <= issue_req.dest_idx;
      end
    end
  end

  // The delay slot is the fetch unit's business; this only redirects.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pc_load_reg   <= 1'b0;
      pc_target_reg <= 32'h0000_0000;
    end else begin
      pc_load_reg <= take && (op == ESLX_OP_JUMP);
      if (take && (op == ESLX_OP_JUMP)) begin
        pc_target_reg <= {issue_req.reg_a[30:0], 1'b0};
      end
    end
  end

  assign mem_req   = mem_reg;
  assign wb        = wb_reg;
  assign pc_load   = pc_load_reg;
  assign pc_target = pc_target_reg;
  assign prefix_constant_register = pfx_reg;

  a_pfx_clear: assert property (
    @(posedge clk) disable iff (!nrst)
    take && (op != ESLX_OP_PREFIX) |=> (pfx_reg == 11'h000))
    else $error("prefix constant not cleared");
  a_pfx_load: assert property (
    @(posedge clk) disable iff (!nrst)
    take && (op == ESLX_OP_PREFIX)
    |=> (pfx_reg == $past(issue_req.prefix_imm)))
    else $error("prefix constant not loaded");
  a_load_aligned: assert property (
    @(posedge clk) disable iff (!nrst)
    mem_req.valid |-> (mem_req.addr[1:0] == 2'b00))
    else $error("load address not word aligned");
  a_reg_addr: assert property (
    @(posedge clk) disable iff (!nrst)
    take && (op == ESLX_OP_LOAD_REG)
    |=> mem_req.valid
        && (mem_req.addr == ($past(issue_req.reg_b) & ALIGN_MASK)))
    else $error("register load address wrong");
  a_load_wb: assert property (
    @(posedge clk) disable iff (!nrst)
    (state_reg == ESLX_ST_WAIT_MEM) && mem_rvalid
    |=> wb.wr_en && (wb.wr_data == $past(mem_rdata)))
    else $error("load data not written back");
  // While a load waits, nothing else may be issued or written back.
  a_wait_quiet: assert property (
    @(posedge clk) disable iff (!nrst)
    (state_reg == ESLX_ST_WAIT_MEM) && !mem_rvalid
    |=> !mem_req.valid && !wb.wr_en && !pc_load)
    else $error("activity while load pending");
  // Expected pointer addresses are rebuilt from the operands, so a wrong
  // base pick or offset scale shows up here and not only in memory.
  a_ptr_short: assert property (
    @(posedge clk) disable iff (!nrst)
    take && (op == ESLX_OP_LOAD_PTR) && (pfx_reg == 11'h000)
    |=> mem_req.valid && (mem_req.addr ==
        (($past(local_base_regs[32*issue_req.base_sel +: 32]) & ALIGN_MASK)
         + (32'($past(issue_req.short_imm)) << WORD_SHIFT))))
    else $error("pointer load address wrong");
  a_ptr_long: assert property (
    @(posedge clk) disable iff (!nrst)
    take && (op == ESLX_OP_LOAD_PTR) && (pfx_reg != 11'h000)
    |=> mem_req.valid && (mem_req.addr ==
        (($past(local_base_regs[32*issue_req.base_sel +: 32]) & ALIGN_MASK)
         + (32'(signed'({$past(pfx_reg), $past(issue_req.short_imm)}))
            << WORD_SHIFT))))
    else $error("prefixed pointer load address wrong");
  a_repl_dest: assert property (
    @(posedge clk) disable iff (!nrst)
    take && is_repl |=> wb.wr_en && (wb.wr_idx == ACC_REG_IDX))
    else $error("replicate not into register zero");
  a_byte_repl: assert property (
    @(posedge clk) disable iff (!nrst)
    take && (op == ESLX_OP_BYTE_REPL)
    |=> (wb.wr_data == {4{$past(issue_req.reg_a[7:0])}}))
    else $error("byte replicate data wrong");
  a_hw_repl: assert property (
    @(posedge clk) disable iff (!nrst)
    take && (op == ESLX_OP_HW_REPL)
    |=> (wb.wr_data == {2{$past(issue_req.reg_a[15:0])}}))
    else $error("halfword replicate data wrong");
  a_hw_extract: assert property (
    @(posedge clk) disable iff (!nrst)
    take && (op == ESLX_OP_HW_EXT_DYN)
    |=> wb.wr_en && (wb.wr_data == (32'h0000_ffff &
        ($past(issue_req.reg_a) >> (16 * $past(issue_req.reg_b[1]))))))
    else $error("dynamic halfword extract wrong");
  a_hw_static: assert property (
    @(posedge clk) disable iff (!nrst)
    take && (op == ESLX_OP_HW_EXT_STAT)
    |=> wb.wr_en && (wb.wr_data == (32'h0000_ffff &
        ($past(issue_req.reg_a) >> (16 * $past(issue_req.short_imm[1]))))))
    else $error("static halfword extract wrong");
  a_byte_dynamic: assert property (
    @(posedge clk) disable iff (!nrst)
    take && (op == ESLX_OP_BYTE_EXT_DYN)
    |=> wb.wr_en && (wb.wr_data == (32'h0000_00ff &
        ($past(issue_req.reg_a) >> (8 * $past(issue_req.reg_b[1:0]))))))
    else $error("dynamic byte extract wrong");
  a_byte_extract: assert property (
    @(posedge clk) disable iff (!nrst)
    take && (op == ESLX_OP_BYTE_EXT_STAT)
    |=> wb.wr_en && (wb.wr_data == (32'h0000_00ff &
        ($past(issue_req.reg_a) >> (8 * $past(issue_req.short_imm[1:0]))))))
    else $error("static byte extract wrong");
  a_shl_imm: assert property (
    @(posedge clk) disable iff (!nrst)
    take && (op == ESLX_OP_SHL_IMM)
    |=> (wb.wr_data ==
         ($past(issue_req.reg_a) << $past(issue_req.short_imm))))
    else $error("immediate left shift wrong");
  a_shr_imm: assert property (
    @(posedge clk) disable iff (!nrst)
    take && (op == ESLX_OP_SHR_IMM)
    |=> (wb.wr_data ==
         ($past(issue_req.reg_a) >> $past(issue_req.short_imm))))
    else $error("immediate right shift wrong");
  a_shl_reg: assert property (
    @(posedge clk) disable iff (!nrst)
    take && (op == ESLX_OP_SHL_REG)
    |=> (wb.wr_data ==
         ($past(issue_req.reg_a) << $past(issue_req.reg_b[4:0]))))
    else $error("register left shift wrong");
  a_shr_reg: assert property (
    @(posedge clk) disable iff (!nrst)
    take && (op == ESLX_OP_SHR_REG)
    |=> (wb.wr_data ==
         ($past(issue_req.reg_a) >> $past(issue_req.reg_b[4:0]))))
    else $error("register right shift wrong");
  a_copy_data: assert property (
    @(posedge clk) disable iff (!nrst)
    take && (op == ESLX_OP_COPY)
    |=> (wb.wr_data == $past(issue_req.reg_b)))
    else $error("copy data wrong");
  a_jump_target: assert property (
    @(posedge clk) disable iff (!nrst)
    take && (op == ESLX_OP_JUMP)
    |=> pc_load && (pc_target == ($past(issue_req.reg_a) << 1)))
    else $error("jump target wrong");

  c_load: cover property (@(posedge clk) disable iff (!nrst)
    take && (op == ESLX_OP_LOAD_PTR) && has_prefix);
  c_jump: cover property (@(posedge clk) disable iff (!nrst) pc_load);
  c_shift: cover property (@(posedge clk) disable iff (!nrst)
    take && (op == ESLX_OP_SHR_REG));
  c_repl: cover property (@(posedge clk) disable iff (!nrst)
    take && is_repl);
  c_load_done: cover property (@(posedge clk) disable iff (!nrst)
    (state_reg == ESLX_ST_WAIT_MEM) && mem_rvalid);

endmodule : eslx_exec

// [dv/eslx_mem_model.sv]
`timescale 1ns/1ps
module eslx_mem_model (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // Request side
  input  wire eslx_pkg::eslx_mem_req_type  mem_req,
  input  wire logic [3:0]                  lat,
  // Answer side
  output logic                             mem_rvalid,
  output logic [31:0]                      mem_rdata
);
  import eslx_pkg::*;
  localparam logic [31:0] FILL = 32'h5ac3_96e1;
  logic        pend_reg;
  logic [3:0]  cnt_reg;
  logic [31:0] addr_reg;
  // Between answers the data lines invert every cycle, so a sample one
  // cycle late sees the complement of the answer word.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_reg   <= 1'b0;
      cnt_reg    <= 4'h0;
      addr_reg   <= 32'h0;
      mem_rvalid <= 1'b0;
      mem_rdata  <= 32'h0;
    end else begin
      mem_rvalid <= 1'b0;
      mem_rdata  <= ~mem_rdata;
      if (mem_req.valid) begin
        pend_reg <= 1'b1;
        cnt_reg  <= lat;
        addr_reg <= mem_req.addr;
      end else if (pend_reg && cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end else if (pend_reg) begin
        pend_reg   <= 1'b0;
        mem_rvalid <= 1'b1;
        mem_rdata  <= addr_reg ^ FILL;
      end
    end
  end
endmodule : eslx_mem_model

// [dv/extract_shift_load_exec_tb.sv]
`timescale 1ns/1ps
module extract_shift_load_exec_tb;
  import eslx_pkg::*;
  localparam logic [31:0] FILL = 32'h5ac3_96e1;
  logic             clk = 1'b0;
  logic             nrst = 1'b0;
  logic             issue_valid = 1'b0;
  eslx_req_type     issue_req = '0;
  logic [127:0]     bases = {32'h4000_0303, 32'h3000_0202,
                             32'h2000_0101, 32'h1000_0003};
  logic [3:0]       lat = 4'h0;
  logic             issue_ready;
  logic             mem_rvalid;
  logic             pc_load;
  logic [31:0]      mem_rdata;
  logic [31:0]      pc_target;
  logic [31:0]      g_data;
  logic [31:0]      g_addr;
  logic [4:0]       g_idx;
  logic             g_rdy;
  logic [10:0]      prefix_instruction;
  eslx_mem_req_type mem_req;
  eslx_wb_type      wb;
  int               errors = 0;
  int               comparisons = 0;

  initial forever #2 clk = ~clk;

  eslx_exec i_dut (.clk(clk), .nrst(nrst), .issue_valid(issue_valid),
    .issue_req(issue_req), .issue_ready(issue_ready),
    .local_base_regs(bases), .mem_req(mem_req), .mem_rvalid(mem_rvalid),
    .mem_rdata(mem_rdata), .wb(wb), .pc_load(pc_load),
    .pc_target(pc_target), .prefix_constant_register(prefix_instruction));

  eslx_mem_model i_mem (.clk(clk), .nrst(nrst), .mem_req(mem_req),
    .lat(lat), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  task automatic send(input eslx_op_type op, input logic [31:0] a,
      input logic [31:0] b, input logic [4:0] im, input logic [1:0] bs,
      input logic [10:0] pf);
    @(posedge clk);
    issue_req   <= '{op, a, b, im, bs, pf, 5'h07};
    issue_valid <= 1'b1;
    #1;
    while (issue_ready !== 1'b1) @(posedge clk) #1;
    @(posedge clk);
    issue_valid <= 1'b0;
  endtask : send

  task automatic run(input eslx_op_type op, input logic [31:0] a,
      input logic [31:0] b, input logic [4:0] im, input logic [1:0] bs);
    int n = 0;
    send(op, a, b, im, bs, 11'h0);
    g_addr = 'x;
    g_rdy  = 1'bx;
    #1;
    while (wb.wr_en !== 1'b1 && pc_load !== 1'b1 && n < 20) begin
      if (mem_req.valid === 1'b1) begin
        g_addr = mem_req.addr;
        g_rdy  = issue_ready;
      end
      @(posedge clk) #1;
      n++;
    end
    g_data = (pc_load === 1'b1) ? pc_target : wb.wr_data;
    g_idx  = wb.wr_idx;
    if (n == 20) g_data = 'x;
  endtask : run

  task automatic t_extract;
    logic [31:0] a;
    a = 32'h8c4d_b2e1;
    for (int n = 0; n < 4; n++) begin
      run(ESLX_OP_HW_EXT_DYN, a, 32'hfff0_0000 | n, 5'h0, 2'h0);
      chk({16'h0, (n > 1) ? a[31:16] : a[15:0]}, g_data);
      run(ESLX_OP_HW_EXT_STAT, a, 32'h0, 5'(n), 2'h0);
      chk({16'h0, (n > 1) ? a[31:16] : a[15:0]}, g_data);
      run(ESLX_OP_BYTE_EXT_DYN, a, 32'hffff_fff0 | n, 5'h1c, 2'h0);
      chk({24'h0, a[8*n +: 8]}, g_data);
      run(ESLX_OP_BYTE_EXT_STAT, a, 32'h0, 5'h1c | 5'(n), 2'h0);
      chk({24'h0, a[8*n +: 8]}, g_data);
    end
  endtask : t_extract

  task automatic t_repl;
    run(ESLX_OP_BYTE_REPL, 32'h1234_56a7, 32'h0, 5'h0, 2'h0);
    chk(32'ha7a7_a7a7, g_data);
    chk(32'h0, 32'(g_idx));
    run(ESLX_OP_HW_REPL, 32'h1234_56a7, 32'h0, 5'h0, 2'h0);
    chk(32'h56a7_56a7, g_data);
    chk(32'h0, 32'(g_idx));
  endtask : t_repl

  task automatic t_shift;
    int cs[4] = '{0, 1, 17, 31};
    logic [31:0] a;
    a = 32'h8000_8001;
    foreach (cs[i]) begin
      run(ESLX_OP_SHL_IMM, a, 32'h0, 5'(cs[i]), 2'h0);
      chk(a << cs[i], g_data);
      run(ESLX_OP_SHR_IMM, a, 32'h0, 5'(cs[i]), 2'h0);
      chk(a >> cs[i], g_data);
      run(ESLX_OP_SHL_REG, a, 32'hffff_ffe0 | cs[i], 5'h0, 2'h0);
      chk(a << cs[i], g_data);
      run(ESLX_OP_SHR_REG, a, 32'hffff_ffe0 | cs[i], 5'h0, 2'h0);
      chk(a >> cs[i], g_data);
    end
  endtask : t_shift

  task automatic t_copy_jump;
    run(ESLX_OP_COPY, 32'h1111_1111, 32'hdead_beef, 5'h0, 2'h0);
    chk(32'hdead_beef, g_data);
    chk(32'h7, 32'(g_idx));
    run(ESLX_OP_JUMP, 32'h8000_0003, 32'h0, 5'h0, 2'h0);
    chk(32'h0000_0006, g_data);
  endtask : t_copy_jump

  task automatic t_loads;
    logic [31:0] e;
    run(ESLX_OP_LOAD_REG, 32'h0, 32'h0000_1237, 5'h0, 2'h0);
    chk(32'h0000_1234, g_addr);
    chk(32'h0000_1234 ^ FILL, g_data);
    chk(32'h7, 32'(g_idx));
    chk(32'h0, 32'(g_rdy));
    lat <= 4'h5;
    for (int s = 0; s < 4; s++) begin
      e = (bases[32*s +: 32] & ALIGN_MASK) + 32'd124;
      run(ESLX_OP_LOAD_PTR, 32'h0, 32'h0, 5'h1f, 2'(s));
      chk(e, g_addr);
      chk(e ^ FILL, g_data);
    end
    send(ESLX_OP_PREFIX, 32'h0, 32'h0, 5'h0, 2'h0, 11'h7ff);
    @(posedge clk) #1;
    chk(32'h7ff, 32'(prefix_instruction));
    run(ESLX_OP_LOAD_PTR, 32'h0, 32'h0, 5'h1f, 2'h1);
    chk(32'h2000_00fc, g_addr);
    chk(32'h0, 32'(prefix_instruction));
    send(ESLX_OP_PREFIX, 32'h0, 32'h0, 5'h0, 2'h0, 11'h003);
    run(ESLX_OP_LOAD_PTR, 32'h0, 32'h0, 5'h02, 2'h3);
    chk(32'h4000_0300 + 32'd392, g_addr);
  endtask : t_loads

  task automatic summarize;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_extract();
    t_repl();
    t_shift();
    t_copy_jump();
    t_loads();
    summarize();
  end

  // The full run needs well under a thousand cycles.
  initial begin
    #20000;
    errors++;
    summarize();
  end
endmodule : extract_shift_load_exec_tb
